// ===== sdiag_alarm_class.sv
`timescale 1ns/10ps
`include "sdiag_params.svh"
module sdiag_alarm_class (
    input wire logic [6:0] code_i,
    output sdiag_pkg::sdiag_alarm_class_t class_o
);
    import sdiag_pkg::*;

    // ------------------------------------------------------------
    // alarm code classes
    // ------------------------------------------------------------
    // the maker range wins over the overlapping reserved span
    always_comb
    begin
        class_o = SD_AC_RESERVED;
        if (code_i == `SD_AT_DIAG)
            class_o = SD_AC_DIAG;
        else if (code_i == `SD_AT_PROCESS)
            class_o = SD_AC_PROCESS;
        else if (code_i == `SD_AT_WITHDRAW)
            class_o = SD_AC_WITHDRAW;
        else if (code_i == `SD_AT_INSERT)
            class_o = SD_AC_INSERT;
        else if (code_i == `SD_AT_STATUS)
            class_o = SD_AC_STATUS;
        else if (code_i == `SD_AT_UPDATE)
            class_o = SD_AC_UPDATE;
        else if (code_i >= `SD_AT_MAKER_LO && code_i <= `SD_AT_MAKER_HI)
            class_o = SD_AC_MAKER;
    end
endmodule

// ===== sdiag_decoder.sv
`timescale 1ns/10ps
`include "sdiag_params.svh"
module sdiag_decoder (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic rec_valid_i,
    input wire logic [7:0] rec_data_i,
    input wire logic rec_last_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic no_reply_flag_o,
    output logic slave_not_ready_flag_o,
    output logic config_mismatch_flag_o,
    output logic extended_present_flag_o,
    output logic feature_missing_flag_o,
    output logic bad_response_flag_o,
    output logic param_error_flag_o,
    output logic other_master_lock_flag_o,
    output logic reparam_request_flag_o,
    output logic static_diag_flag_o,
    output logic watchdog_active_flag_o,
    output logic input_freeze_flag_o,
    output logic output_sync_flag_o,
    output logic deactivated_flag_o,
    output logic extended_overflow_flag_o,
    output logic [7:0] locking_master_address_o,
    output logic [15:0] station_type_code_o,
    output logic record_done_o,
    output logic malformed_o,
    output logic alarm_valid_o,
    output logic alarm_is_status_o,
    output sdiag_pkg::sdiag_alarm_class_t alarm_class_o,
    output logic [7:0] slot_number_o
);
    import sdiag_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    sdiag_state_t st_q, st_d;
    logic [7:0] idx_q, idx_d;
    logic [8:0] blk_end_q, blk_end_d;
    logic [7:0] stat0_q, stat0_d;
    logic [7:0] stat1_q, stat1_d;
    logic stat2_q, stat2_d;
    logic [7:0] maddr_q, maddr_d;
    logic [15:0] ident_q, ident_d;
    logic bad_q, bad_d;
    logic done_q, done_d;
    logic [7:0] nblk_q, nblk_d;
    logic cap_q, cap_d;
    logic seen_q, seen_d;
    logic [7:0] cap_base_q, cap_base_d;
    logic [7:0] atype_q, atype_d;
    logic [7:0] slot_q, slot_d;
    logic [7:0] aspec_q, aspec_d;
    logic avalid_q, avalid_d;
    sdiag_alarm_class_t aclass_q, aclass_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] rdata_q, rdata_d;

    logic [5:0] hdr_len;
    sdiag_hdr_type_t hdr_type;
    logic hdr_zero;
    sdiag_alarm_class_t code_class;
    logic take;
    logic at_hdr;
    logic [7:0] cap_off;

    sdiag_hdr_split u_hdr (
        .hdr_i(rec_data_i),
        .len_o(hdr_len),
        .type_o(hdr_type),
        .zero_o(hdr_zero)
    );

    sdiag_alarm_class u_acls (
        .code_i(rec_data_i[6:0]),
        .class_o(code_class)
    );

    assign take = rec_valid_i && ctrl_q[`SD_CTRL_EN];
    assign at_hdr = take && st_q == ST_EXT && {1'b0, idx_q} == blk_end_q;
    assign cap_off = idx_q - cap_base_q;

    // ------------------------------------------------------------
    // record walker
    // ------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        idx_d = idx_q;
        blk_end_d = blk_end_q;
        stat0_d = stat0_q;
        stat1_d = stat1_q;
        stat2_d = stat2_q;
        maddr_d = maddr_q;
        ident_d = ident_q;
        bad_d = bad_q;
        done_d = 1'b0;
        nblk_d = nblk_q;
        cap_d = cap_q;
        seen_d = seen_q;
        cap_base_d = cap_base_q;
        atype_d = atype_q;
        slot_d = slot_q;
        aspec_d = aspec_q;
        avalid_d = avalid_q;
        aclass_d = aclass_q;
        if (take)
        begin
            // saturate so an endless record cannot wrap into byte 0
            if (idx_q != `SD_IDX_MAX)
                idx_d = idx_q + 8'h01;
            unique case (st_q)
                ST_FIXED:
                begin
                    unique case (idx_q)
                        `SD_IDX_B0:
                        begin
                            stat0_d = rec_data_i;
                            bad_d = 1'b0;
                            nblk_d = 8'h00;
                            cap_d = 1'b0;
                            seen_d = 1'b0;
                            avalid_d = 1'b0;
                        end
                        `SD_IDX_B1:
                            stat1_d = rec_data_i;
                        `SD_IDX_B2:
                            stat2_d = rec_data_i[`SD_B2_OVERFLOW];
                        `SD_IDX_B3:
                            maddr_d = rec_data_i;
                        `SD_IDX_B4:
                            ident_d[15:8] = rec_data_i;
                        default:
                        begin
                            ident_d[7:0] = rec_data_i;
                            st_d = ST_EXT;
                            blk_end_d = `SD_EXT_START;
                        end
                    endcase
                end
                ST_EXT:
                begin
                    if (at_hdr)
                    begin
                        cap_d = 1'b0;
                        if (hdr_zero)
                        begin
                            // a zero length would stall the walk forever
                            bad_d = 1'b1;
                            st_d = ST_BAD;
                        end
                        else
                        begin
                            blk_end_d = {1'b0, idx_q}
                                + {3'b000, hdr_len};
                            nblk_d = nblk_q + 8'h01;
                            if (hdr_type == SD_HT_MAKER
                                && ctrl_q[`SD_CTRL_ACYC] && !seen_q)
                            begin
                                cap_d = 1'b1;
                                seen_d = 1'b1;
                                cap_base_d = idx_q;
                            end
                        end
                    end
                    else if (cap_q)
                    begin
                        if (cap_off == `SD_ALM_OFF_TYPE)
                        begin
                            atype_d = rec_data_i;
                            aclass_d = code_class;
                        end
                        else if (cap_off == `SD_ALM_OFF_SLOT)
                            slot_d = rec_data_i;
                        else if (cap_off == `SD_ALM_OFF_SPEC)
                        begin
                            aspec_d = rec_data_i;
                            avalid_d = 1'b1;
                            cap_d = 1'b0;
                        end
                    end
                end
                ST_BAD:
                    bad_d = 1'b1;
            endcase
            if (rec_last_i)
            begin
                // a short fixed part or a block cut off by the end
                if ((st_q == ST_FIXED && idx_q != `SD_IDX_B5)
                    || (st_d == ST_EXT
                    && blk_end_d != {1'b0, idx_q} + 9'h001))
                    bad_d = 1'b1;
                st_d = ST_FIXED;
                idx_d = `SD_IDX_B0;
                cap_d = 1'b0;
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            st_q <= ST_FIXED;
            idx_q <= `SD_IDX_B0;
            blk_end_q <= `SD_EXT_START;
            stat0_q <= 8'h00;
            stat1_q <= 8'h00;
            stat2_q <= 1'b0;
            maddr_q <= 8'h00;
            ident_q <= 16'h0000;
            bad_q <= 1'b0;
            done_q <= 1'b0;
            nblk_q <= 8'h00;
            cap_q <= 1'b0;
            seen_q <= 1'b0;
            cap_base_q <= 8'h00;
            atype_q <= 8'h00;
            slot_q <= 8'h00;
            aspec_q <= 8'h00;
            avalid_q <= 1'b0;
            aclass_q <= SD_AC_RESERVED;
        end
        else
        begin
            st_q <= st_d;
            idx_q <= idx_d;
            blk_end_q <= blk_end_d;
            stat0_q <= stat0_d;
            stat1_q <= stat1_d;
            stat2_q <= stat2_d;
            maddr_q <= maddr_d;
            ident_q <= ident_d;
            bad_q <= bad_d;
            done_q <= done_d;
            nblk_q <= nblk_d;
            cap_q <= cap_d;
            seen_q <= seen_d;
            cap_base_q <= cap_base_d;
            atype_q <= atype_d;
            slot_q <= slot_d;
            aspec_q <= aspec_d;
            avalid_q <= avalid_d;
            aclass_q <= aclass_d;
        end
    end

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    always_comb
    begin
        ctrl_d = ctrl_q;
        rdata_d = 8'h00;
        if (reg_wr_i && reg_addr_i == `SD_OFF_CTRL)
            ctrl_d = reg_wdata_i & `SD_CTRL_MASK;
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                `SD_OFF_STAT0: rdata_d = stat0_q;
                `SD_OFF_STAT1: rdata_d = stat1_q & 8'hbf;
                `SD_OFF_STAT2: rdata_d = {stat2_q, 7'h00};
                `SD_OFF_MADDR: rdata_d = maddr_q;
                `SD_OFF_IDHI: rdata_d = ident_q[15:8];
                `SD_OFF_IDLO: rdata_d = ident_q[7:0];
                `SD_OFF_WALK: rdata_d = {5'h00, avalid_q, bad_q,
                    st_q == ST_FIXED};
                `SD_OFF_ATYPE: rdata_d = atype_q;
                `SD_OFF_SLOT: rdata_d = slot_q;
                `SD_OFF_ASPEC: rdata_d = aspec_q;
                `SD_OFF_NBLK: rdata_d = nblk_q;
                `SD_OFF_CTRL: rdata_d = ctrl_q;
                `SD_OFF_ACLASS: rdata_d = {5'h00, aclass_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            ctrl_q <= `SD_CTRL_RST;
            rdata_q <= 8'h00;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata_o = rdata_q;
    assign no_reply_flag_o = stat0_q[`SD_B0_NO_REPLY];
    assign slave_not_ready_flag_o = stat0_q[`SD_B0_NOT_READY];
    assign config_mismatch_flag_o = stat0_q[`SD_B0_CFG_MISMATCH];
    assign extended_present_flag_o = stat0_q[`SD_B0_EXT_PRESENT];
    assign feature_missing_flag_o = stat0_q[`SD_B0_FEAT_MISSING];
    assign bad_response_flag_o = stat0_q[`SD_B0_BAD_RESP];
    assign param_error_flag_o = stat0_q[`SD_B0_PARAM_ERR];
    assign other_master_lock_flag_o = stat0_q[`SD_B0_OTHER_LOCK];
    assign reparam_request_flag_o = stat1_q[`SD_B1_REPARAM];
    assign static_diag_flag_o = stat1_q[`SD_B1_STATIC];
    assign watchdog_active_flag_o = stat1_q[`SD_B1_WATCHDOG];
    assign input_freeze_flag_o = stat1_q[`SD_B1_FREEZE];
    assign output_sync_flag_o = stat1_q[`SD_B1_SYNC];
    assign deactivated_flag_o = stat1_q[`SD_B1_DEACT];
    assign extended_overflow_flag_o = stat2_q;
    assign locking_master_address_o = maddr_q;
    assign station_type_code_o = ident_q;
    assign record_done_o = done_q;
    assign malformed_o = bad_q;
    assign alarm_valid_o = avalid_q;
    assign alarm_is_status_o = atype_q[`SD_ALM_STATUS_BIT];
    assign alarm_class_o = aclass_q;
    assign slot_number_o = slot_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_byte0;
        take && st_q == ST_FIXED && idx_q == `SD_IDX_B0 |=>
            no_reply_flag_o == $past(rec_data_i[0]);
    endproperty
    a_byte0: assert property (p_byte0)
        else $error("byte 0 flags not captured");

    property p_master;
        take && st_q == ST_FIXED && idx_q == `SD_IDX_B3 |=>
            locking_master_address_o == $past(rec_data_i);
    endproperty
    a_master: assert property (p_master)
        else $error("master address not captured");

    property p_ext_start;
        take && !rec_last_i && st_q == ST_FIXED
            && idx_q == `SD_IDX_B5 |=>
            st_q == ST_EXT && blk_end_q == `SD_EXT_START;
    endproperty
    a_ext_start: assert property (p_ext_start)
        else $error("extended walk not at byte 6");

    property p_hdr_adv;
        at_hdr && !hdr_zero && !rec_last_i |=>
            blk_end_q == $past({1'b0, idx_q} + {3'b000, hdr_len});
    endproperty
    a_hdr_adv: assert property (p_hdr_adv)
        else $error("block end not advanced by length");

    property p_zero_len;
        at_hdr && hdr_zero |=> malformed_o;
    endproperty
    a_zero_len: assert property (p_zero_len)
        else $error("zero length header not flagged");

    property p_cap_gate;
        $rose(cap_q) |-> $past(hdr_type == SD_HT_MAKER
            && ctrl_q[`SD_CTRL_ACYC]);
    endproperty
    a_cap_gate: assert property (p_cap_gate)
        else $error("alarm capture on wrong block type");

    property p_alarm_done;
        take && !at_hdr && cap_q && st_q == ST_EXT
            && cap_off == `SD_ALM_OFF_SPEC |=>
            alarm_valid_o && aspec_q == $past(rec_data_i);
    endproperty
    a_alarm_done: assert property (p_alarm_done)
        else $error("alarm block not completed");

    property p_rsvd;
        reg_rd_i && reg_addr_i == `SD_OFF_STAT2 |=>
            reg_rdata_o[6:0] == 7'h00
            && reg_rdata_o[7] == $past(stat2_q);
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("byte 2 reserved bits not zero");

    property p_done;
        take && rec_last_i |=> record_done_o
            ##1 record_done_o == $past(take && rec_last_i);
    endproperty
    a_done: assert property (p_done)
        else $error("record end pulse wrong");
endmodule

// ===== sdiag_hdr_split.sv
`timescale 1ns/10ps
`include "sdiag_params.svh"
module sdiag_hdr_split (
    input wire logic [7:0] hdr_i,
    output logic [5:0] len_o,
    output sdiag_pkg::sdiag_hdr_type_t type_o,
    output logic zero_o
);
    import sdiag_pkg::*;

    // ------------------------------------------------------------
    // header byte fields
    // ------------------------------------------------------------
    always_comb
    begin
        len_o = hdr_i[`SD_HDR_LEN_HI:0];
        type_o = sdiag_hdr_type_t'(hdr_i[7:`SD_HDR_TYPE_LO]);
        zero_o = (hdr_i[`SD_HDR_LEN_HI:0] == 6'h00);
    end
endmodule

// ===== sdiag_params.svh
`ifndef SDIAG_PARAMS_SVH
`define SDIAG_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SD_OFF_STAT0 8'h00
`define SD_OFF_STAT1 8'h01
`define SD_OFF_STAT2 8'h02
`define SD_OFF_MADDR 8'h03
`define SD_OFF_IDHI 8'h04
`define SD_OFF_IDLO 8'h05
`define SD_OFF_WALK 8'h06
`define SD_OFF_ATYPE 8'h07
`define SD_OFF_SLOT 8'h08
`define SD_OFF_ASPEC 8'h09
`define SD_OFF_NBLK 8'h0a
`define SD_OFF_CTRL 8'h0b
`define SD_OFF_ACLASS 8'h0c

// ----------------------------------------------------------------
// reset values and control bits
// ----------------------------------------------------------------
`define SD_CTRL_RST 8'h02
`define SD_CTRL_ACYC 0
`define SD_CTRL_EN 1
`define SD_CTRL_MASK 8'h03

// ----------------------------------------------------------------
// record layout
// ----------------------------------------------------------------
`define SD_IDX_B0 8'h00
`define SD_IDX_B1 8'h01
`define SD_IDX_B2 8'h02
`define SD_IDX_B3 8'h03
`define SD_IDX_B4 8'h04
`define SD_IDX_B5 8'h05
`define SD_IDX_MAX 8'hff
`define SD_EXT_START 9'h006
`define SD_B0_NO_REPLY 0
`define SD_B0_NOT_READY 1
`define SD_B0_CFG_MISMATCH 2
`define SD_B0_EXT_PRESENT 3
`define SD_B0_FEAT_MISSING 4
`define SD_B0_BAD_RESP 5
`define SD_B0_PARAM_ERR 6
`define SD_B0_OTHER_LOCK 7
`define SD_B1_REPARAM 0
`define SD_B1_STATIC 1
`define SD_B1_WATCHDOG 3
`define SD_B1_FREEZE 4
`define SD_B1_SYNC 5
`define SD_B1_DEACT 7
`define SD_B2_OVERFLOW 7

// ----------------------------------------------------------------
// extended block layout
// ----------------------------------------------------------------
`define SD_HDR_LEN_HI 5
`define SD_HDR_TYPE_LO 6
`define SD_ALM_OFF_TYPE 8'h01
`define SD_ALM_OFF_SLOT 8'h02
`define SD_ALM_OFF_SPEC 8'h03
`define SD_ALM_STATUS_BIT 7
`define SD_AT_DIAG 7'h01
`define SD_AT_PROCESS 7'h02
`define SD_AT_WITHDRAW 7'h03
`define SD_AT_INSERT 7'h04
`define SD_AT_STATUS 7'h05
`define SD_AT_UPDATE 7'h06
`define SD_AT_MAKER_LO 7'h14
`define SD_AT_MAKER_HI 7'h7e

`endif

// ===== sdiag_pkg.sv
package sdiag_pkg;

    typedef enum logic [1:0] {
        SD_HT_MAKER = 2'h0,
        SD_HT_MODULE = 2'h1,
        SD_HT_CHANNEL = 2'h2,
        SD_HT_RSVD = 2'h3
    } sdiag_hdr_type_t;

    typedef enum logic [2:0] {
        SD_AC_RESERVED = 3'h0,
        SD_AC_DIAG = 3'h1,
        SD_AC_PROCESS = 3'h2,
        SD_AC_WITHDRAW = 3'h3,
        SD_AC_INSERT = 3'h4,
        SD_AC_STATUS = 3'h5,
        SD_AC_UPDATE = 3'h6,
        SD_AC_MAKER = 3'h7
    } sdiag_alarm_class_t;

    typedef enum logic [1:0] {
        ST_FIXED,
        ST_EXT,
        ST_BAD
    } sdiag_state_t;

endpackage

// ===== sdiag_slave_model.sv
`timescale 1ns/10ps
module sdiag_slave_model (
    input wire logic clk_i,
    output logic rec_valid_o,
    output logic [7:0] rec_data_o,
    output logic rec_last_o
);
    // ----
    // record sender
    // ----
    initial
    begin
        rec_valid_o = 1'b0;
        rec_data_o = 8'h00;
        rec_last_o = 1'b0;
    end

    // idle cycles carry a changing byte so a stale value is never reused
    task automatic send(input logic [7:0] b[$], input int gap);
        for (int i = 0; i < b.size(); i++)
        begin
            repeat (gap)
            begin
                @(posedge clk_i);
                rec_valid_o <= 1'b0;
                rec_data_o <= ~rec_data_o;
            end
            @(posedge clk_i);
            rec_valid_o <= 1'b1;
            rec_data_o <= b[i];
            rec_last_o <= (i == b.size() - 1);
        end
        @(posedge clk_i);
        rec_valid_o <= 1'b0;
        rec_last_o <= 1'b0;
        rec_data_o <= ~b[b.size() - 1];
    endtask
endmodule

// ===== slave_diag_decoder_test.sv
`timescale 1ns/10ps
module slave_diag_decoder_test;
    import sdiag_pkg::*;
    // ----
    // signals
    // ----
    logic clk_i, sys_rst_i, rec_valid_i, rec_last_i, reg_wr_i, reg_rd_i;
    logic [7:0] rec_data_i, reg_addr_i, reg_wdata_i, reg_rdata_o, f0, f1;
    logic no_reply_flag_o, slave_not_ready_flag_o, config_mismatch_flag_o;
    logic extended_present_flag_o, feature_missing_flag_o, bad_response_flag_o;
    logic param_error_flag_o, other_master_lock_flag_o, reparam_request_flag_o;
    logic static_diag_flag_o, watchdog_active_flag_o, input_freeze_flag_o;
    logic output_sync_flag_o, deactivated_flag_o, extended_overflow_flag_o;
    logic record_done_o, malformed_o, alarm_valid_o, alarm_is_status_o;
    logic [7:0] locking_master_address_o, slot_number_o;
    logic [15:0] station_type_code_o;
    sdiag_alarm_class_t alarm_class_o;
    int miscompares = 0, total_checks = 0, cycles = 0;
    logic [7:0] q[$];
    logic [6:0] codes[12] = '{0, 1, 2, 3, 4, 5, 6, 7, 19, 20, 126, 127};

    assign f0 = {other_master_lock_flag_o, param_error_flag_o,
        bad_response_flag_o, feature_missing_flag_o, extended_present_flag_o,
        config_mismatch_flag_o, slave_not_ready_flag_o, no_reply_flag_o};
    assign f1 = {deactivated_flag_o, 1'b0, output_sync_flag_o,
        input_freeze_flag_o, watchdog_active_flag_o, 1'b0,
        static_diag_flag_o, reparam_request_flag_o};

    sdiag_decoder DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .rec_valid_i(rec_valid_i), .rec_data_i(rec_data_i),
        .rec_last_i(rec_last_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .no_reply_flag_o(no_reply_flag_o),
        .slave_not_ready_flag_o(slave_not_ready_flag_o),
        .config_mismatch_flag_o(config_mismatch_flag_o),
        .extended_present_flag_o(extended_present_flag_o),
        .feature_missing_flag_o(feature_missing_flag_o),
        .bad_response_flag_o(bad_response_flag_o),
        .param_error_flag_o(param_error_flag_o),
        .other_master_lock_flag_o(other_master_lock_flag_o),
        .reparam_request_flag_o(reparam_request_flag_o),
        .static_diag_flag_o(static_diag_flag_o),
        .watchdog_active_flag_o(watchdog_active_flag_o),
        .input_freeze_flag_o(input_freeze_flag_o),
        .output_sync_flag_o(output_sync_flag_o),
        .deactivated_flag_o(deactivated_flag_o),
        .extended_overflow_flag_o(extended_overflow_flag_o),
        .locking_master_address_o(locking_master_address_o),
        .station_type_code_o(station_type_code_o),
        .record_done_o(record_done_o), .malformed_o(malformed_o),
        .alarm_valid_o(alarm_valid_o), .alarm_is_status_o(alarm_is_status_o),
        .alarm_class_o(alarm_class_o), .slot_number_o(slot_number_o));

    sdiag_slave_model SLV (.clk_i(clk_i), .rec_valid_o(rec_valid_i),
        .rec_data_o(rec_data_i), .rec_last_o(rec_last_i));

    // ----
    // helpers
    // ----
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic chk(input logic [15:0] g, e, input string m);
        total_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %0t %s: got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // read data stand one cycle only, so they are sampled right after it
    task automatic rd(input logic [7:0] a, e);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, e, "register read");
    endtask

    task automatic mk(input logic [7:0] b0, hdr, ab1);
        q = '{b0, 8'hff, 8'hff, 8'h21, 8'h12, 8'h34, hdr, ab1, 8'hfe, 8'h5e};
    endtask

    task automatic send(input int gap);
        SLV.send(q, gap);
        #1 chk(record_done_o, 1'b1, "record done");
    endtask

    function automatic sdiag_alarm_class_t cls(input logic [6:0] c);
        if (c >= 7'h01 && c <= 7'h06)
            return sdiag_alarm_class_t'(c[2:0]);
        if (c >= 7'h14 && c <= 7'h7e)
            return SD_AC_MAKER;
        return SD_AC_RESERVED;
    endfunction

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // generous ceiling: the whole run needs well under a thousand cycles
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            report_and_stop;
        end
    end

    // ----
    // tests
    // ----
    initial
    begin
        sys_rst_i = 1'b1;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(8'h0b, 8'h02);
        rd(8'h00, 8'h00);
        $display("test reset done");
        wr(8'h0b, 8'h03);
        for (int i = 0; i < 12; i++)
        begin
            mk(8'h01 << (i % 8), 8'h04, {i[0], codes[i]});
            send(i % 3);
            chk(f0, 8'h01 << (i % 8), "byte0 flags");
            chk(f1, 8'hbb, "byte1 flags");
            chk(extended_overflow_flag_o, 1'b1, "overflow");
            chk(locking_master_address_o, 8'h21, "master");
            chk(station_type_code_o, 16'h1234, "ident");
            chk(alarm_class_o, cls(codes[i]), "class");
            chk(alarm_is_status_o, i[0], "status bit");
            chk(slot_number_o, 8'hfe, "slot");
            chk(alarm_valid_o, 1'b1, "alarm valid");
        end
        rd(8'h00, 8'h08);
        rd(8'h01, 8'hbf);
        rd(8'h02, 8'h80);
        rd(8'h07, 8'hff);
        rd(8'h09, 8'h5e);
        rd(8'h03, 8'h21);
        rd(8'h04, 8'h12);
        rd(8'h05, 8'h34);
        rd(8'h08, 8'hfe);
        rd(8'h0c, 8'h00);
        rd(8'h20, 8'h00);
        wr(8'h00, 8'h55);
        rd(8'h00, 8'h08);
        $display("test fixed part done");
        q = '{8'h08, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h43, 8'haa,
            8'hbb, 8'h83, 8'h01, 8'h22, 8'h04, 8'h01, 8'h05, 8'h10};
        send(0);
        chk(malformed_o, 1'b0, "chain ok");
        chk(slot_number_o, 8'h05, "third block slot");
        rd(8'h0a, 8'h03);
        $display("test block chain done");
        mk(8'h00, 8'h00, 8'h01);
        send(1);
        chk(malformed_o, 1'b1, "zero length");
        q = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h45, 8'h01};
        send(0);
        chk(malformed_o, 1'b1, "overlong block");
        mk(8'h00, 8'h04, 8'h02);
        send(0);
        chk(malformed_o, 1'b0, "cleared");
        $display("test malformed done");
        wr(8'h0b, 8'h02);
        mk(8'h80, 8'h04, 8'h01);
        send(2);
        chk(alarm_valid_o, 1'b0, "maker block");
        chk(f0, 8'h80, "lock flag");
        rd(8'h06, 8'h01);
        $display("test maker block done");
        wr(8'h0b, 8'hff);
        rd(8'h0b, 8'h03);
        wr(8'h0b, 8'h00);
        mk(8'h01, 8'h04, 8'h01);
        SLV.send(q, 0);
        #1 chk(record_done_o, 1'b0, "disabled record done");
        chk(f0, 8'h80, "disabled flags");
        $display("test disable done");
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        #1 chk(f0, 8'h00, "reset flags");
        chk(station_type_code_o, 16'h0000, "reset ident");
        chk(locking_master_address_o, 8'h00, "reset master");
        rd(8'h0b, 8'h02);
        $display("test mid reset done");
        report_and_stop;
    end
endmodule
